// File: core/pbphy_pkg.sv
// Purpose: Shared constants and types of the packet bus PHY-side transfer block
// Assumes: Level 2 and level 3 packet bus signalling, one device hosting several ports
// Notes:   Widths and port counts are module parameters; only fixed values live here
package pbphy_pkg;

	// Synchroniser depth for levels entering the link domain
	localparam int PBPHY_SYNC_STAGES = 2;

	// Values after reset
	localparam logic PBPHY_RST_LOW     = 1'b0;
	localparam logic PBPHY_RST_OE_N    = 1'b1;

	// Receive sequencer for in-band addressing, one bit changing per step except data back to idle
	typedef enum logic [1:0] {
		PBPHY_RX_IDLE = 2'b00,
		PBPHY_RX_ADDR = 2'b01,
		PBPHY_RX_DATA = 2'b11
	} pbphy_rx_state_t;

endpackage

// File: core/pbphy_transfer.sv
// Purpose: PHY-side transfer logic at the packet system bus, level 2 and level 3
// Assumes: sys_clk is the bus clock; port status levels come from the core_clk domain
// Notes:   Three-state outputs are split into value and active-low output enable
`timescale 1ns/100ps

module pbphy_transfer #(
	parameter int             NUM_PORTS = 4,
	parameter int             DW        = 8,
	parameter int             AW        = 5,
	parameter logic [AW-1:0]  PORT_BASE = 5'h00,
	parameter int             PW        = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  sys_clk,
	input  wire logic [NUM_PORTS-1:0]  core_tx_space,
	input  wire logic [NUM_PORTS-1:0]  core_rx_avail,
	input  wire logic                  core_level3_mode,
	output logic                       core_tx_packet_done,
	input  wire logic [AW-1:0]         tx_port_address,
	input  wire logic                  transmit_enable,
	input  wire logic [DW-1:0]         tx_data_bus,
	input  wire logic                  tx_start_of_packet,
	input  wire logic                  tx_end_of_packet,
	input  wire logic                  tx_in_band_address_strobe,
	output logic                       tx_polled_space_available,
	output logic                       tx_selected_space_available,
	output logic                       tx_selected_space_oe_n,
	output logic                       tx_byte_valid,
	output logic [DW-1:0]              tx_byte_data,
	output logic [PW-1:0]              tx_byte_port,
	output logic                       tx_byte_sop,
	output logic                       tx_byte_eop,
	input  wire logic [AW-1:0]         rx_port_address,
	input  wire logic                  rx_read_enable,
	output logic                       rx_polled_data_available,
	output logic                       rx_valid,
	output logic [DW-1:0]              rx_data_bus,
	output logic                       rx_start_of_packet,
	output logic                       rx_end_of_packet,
	output logic                       rx_packet_error,
	output logic                       rx_bus_oe_n,
	output logic                       rx_in_band_address_strobe,
	output logic [PW-1:0]              rx_src_sel,
	output logic                       rx_src_take,
	input  wire logic [DW-1:0]         rx_src_data,
	input  wire logic                  rx_src_eop,
	input  wire logic                  rx_src_err
);
	import pbphy_pkg::*;

	// Address decode, shared by transmit, receive and in-band paths
	function automatic logic addr_ours(input logic [AW-1:0] a);
		logic [AW:0] off;
		off = {1'b0, a} - {1'b0, PORT_BASE};
		return (off < (AW+1)'(NUM_PORTS));
	endfunction

	function automatic logic [PW-1:0] addr_idx(input logic [AW-1:0] a);
		logic [AW:0] off;
		off = {1'b0, a} - {1'b0, PORT_BASE};
		return off[PW-1:0];
	endfunction

	// Lowest ready port wins; fixed priority keeps the logic small
	function automatic logic [PW:0] first_set(input logic [NUM_PORTS-1:0] v);
		logic [PW:0] r;
		r = '0;
		for (int i = NUM_PORTS - 1; i >= 0; i--)
		begin
			if (v[i])
			begin
				r = {1'b1, PW'(i)};
			end
		end
		return r;
	endfunction

	// Level crossing into the link domain
	logic [NUM_PORTS-1:0] space_m_q;
	logic [NUM_PORTS-1:0] space_s_q;
	logic [NUM_PORTS-1:0] avail_m_q;
	logic [NUM_PORTS-1:0] avail_s_q;
	logic                 mode_m_q;
	logic                 mode_s_q;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			space_m_q <= '0;
			space_s_q <= '0;
			avail_m_q <= '0;
			avail_s_q <= '0;
			mode_m_q  <= PBPHY_RST_LOW;
			mode_s_q  <= PBPHY_RST_LOW;
		end
		else
		begin
			space_m_q <= core_tx_space;
			space_s_q <= space_m_q;
			avail_m_q <= core_rx_avail;
			avail_s_q <= avail_m_q;
			mode_m_q  <= core_level3_mode;
			mode_s_q  <= mode_m_q;
		end
	end

	// Transmit side
	logic            tx_hit;
	logic [PW-1:0]   tx_idx;
	logic            tx_l3_addr;
	logic            tx_start;
	logic            tx_take;
	logic [PW-1:0]   tx_take_port;
	logic            tx_drive_q;
	logic            tx_busy_q;
	logic [PW-1:0]   tx_sel_q;
	logic            tx_done_tgl_q;

	assign tx_hit     = addr_ours(tx_port_address);
	assign tx_idx     = addr_idx(tx_port_address);
	assign tx_l3_addr = mode_s_q && tx_in_band_address_strobe && !transmit_enable;
	assign tx_start   = transmit_enable && tx_start_of_packet;

	always_comb
	begin
		tx_take      = 1'b0;
		tx_take_port = tx_sel_q;
		if (transmit_enable && !(mode_s_q && tx_in_band_address_strobe))
		begin
			if (tx_start && !mode_s_q)
			begin
				tx_take      = tx_hit;
				tx_take_port = tx_idx;
			end
			else if (tx_start)
			begin
				tx_take = tx_drive_q;
			end
			else
			begin
				tx_take = tx_busy_q && tx_drive_q;
			end
		end
	end

	// Port selection and packet framing
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_drive_q <= PBPHY_RST_LOW;
			tx_busy_q  <= PBPHY_RST_LOW;
			tx_sel_q   <= '0;
		end
		else if (tx_l3_addr)
		begin
			tx_drive_q <= addr_ours(tx_data_bus[AW-1:0]);
			tx_sel_q   <= addr_idx(tx_data_bus[AW-1:0]);
			tx_busy_q  <= 1'b0;
		end
		else if (tx_start && !mode_s_q)
		begin
			tx_drive_q <= tx_hit;
			tx_sel_q   <= tx_idx;
			tx_busy_q  <= tx_hit;
		end
		else if (tx_start)
		begin
			tx_busy_q <= tx_drive_q;
		end
		else if (mode_s_q && !transmit_enable)
		begin
			tx_busy_q <= 1'b0;
		end
		else if (tx_take && tx_end_of_packet)
		begin
			tx_busy_q <= 1'b0;
		end
	end

	// Status answers; level 2 keeps driving after the end until a new start
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_polled_space_available   <= PBPHY_RST_LOW;
			tx_selected_space_available <= PBPHY_RST_LOW;
			tx_selected_space_oe_n      <= PBPHY_RST_OE_N;
		end
		else
		begin
			tx_polled_space_available   <= tx_hit && space_s_q[tx_idx];
			tx_selected_space_available <= tx_drive_q && (tx_busy_q || !mode_s_q)
				&& space_s_q[tx_sel_q];
			tx_selected_space_oe_n      <= !tx_drive_q;
		end
	end

	// Accepted bytes toward the port buffers
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_byte_valid <= PBPHY_RST_LOW;
			tx_byte_data  <= '0;
			tx_byte_port  <= '0;
			tx_byte_sop   <= PBPHY_RST_LOW;
			tx_byte_eop   <= PBPHY_RST_LOW;
			tx_done_tgl_q <= PBPHY_RST_LOW;
		end
		else
		begin
			tx_byte_valid <= tx_take;
			tx_byte_data  <= tx_take ? tx_data_bus : tx_byte_data;
			tx_byte_port  <= tx_take ? tx_take_port : tx_byte_port;
			tx_byte_sop   <= tx_take && tx_start_of_packet;
			tx_byte_eop   <= tx_take && tx_end_of_packet;
			if (tx_take && tx_end_of_packet)
			begin
				tx_done_tgl_q <= !tx_done_tgl_q;
			end
		end
	end

	// Packet-end event into the core domain as a toggle
	logic [2:0] done_sync_q;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			done_sync_q         <= '0;
			core_tx_packet_done <= PBPHY_RST_LOW;
		end
		else
		begin
			done_sync_q         <= {done_sync_q[1:0], tx_done_tgl_q};
			core_tx_packet_done <= done_sync_q[2] ^ done_sync_q[1];
		end
	end

	// Receive side
	pbphy_rx_state_t       rx_state_q;
	logic [PW-1:0]         rx_cur_q;
	logic [NUM_PORTS-1:0]  rx_mid_q;
	logic                  rx_eop_hold_q;
	logic                  rx_hit;
	logic [PW-1:0]         rx_idx;
	logic [PW:0]           rx_pick;
	logic                  rx_emit;
	logic                  rx_release;

	assign rx_hit  = addr_ours(rx_port_address);
	assign rx_idx  = addr_idx(rx_port_address);
	assign rx_pick = first_set(avail_s_q);
	// Bus release at level 2 only after enable drops and the address moves away
	assign rx_release = !rx_read_enable && (!rx_hit || rx_idx != rx_cur_q);

	always_comb
	begin
		rx_src_sel = mode_s_q ? rx_cur_q : rx_idx;
		if (mode_s_q)
		begin
			rx_emit = rx_read_enable && (rx_state_q == PBPHY_RX_ADDR
				|| rx_state_q == PBPHY_RX_DATA);
		end
		else
		begin
			rx_emit = rx_read_enable && rx_hit && !rx_eop_hold_q
				&& avail_s_q[rx_idx];
		end
		rx_src_take = rx_emit;
	end

	// In-band sequencer; idle at level 2
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_state_q <= PBPHY_RX_IDLE;
		end
		else
		begin
			case (rx_state_q)
				PBPHY_RX_IDLE:
				begin
					if (mode_s_q && rx_read_enable && rx_pick[PW])
					begin
						rx_state_q <= PBPHY_RX_ADDR;
					end
				end
				PBPHY_RX_ADDR:
				begin
					rx_state_q <= PBPHY_RX_DATA;
					if (rx_emit && rx_src_eop)
					begin
						rx_state_q <= PBPHY_RX_IDLE;
					end
				end
				PBPHY_RX_DATA:
				begin
					if (!mode_s_q || (rx_emit && rx_src_eop))
					begin
						rx_state_q <= PBPHY_RX_IDLE;
					end
				end
				default:
				begin
					rx_state_q <= PBPHY_RX_IDLE;
				end
			endcase
		end
	end

	// Current port and per-port packet progress
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_cur_q      <= '0;
			rx_mid_q      <= '0;
			rx_eop_hold_q <= PBPHY_RST_LOW;
		end
		else
		begin
			rx_eop_hold_q <= rx_emit && rx_src_eop;
			if (mode_s_q && rx_state_q == PBPHY_RX_IDLE && rx_read_enable && rx_pick[PW])
			begin
				rx_cur_q <= rx_pick[PW-1:0];
			end
			else if (!mode_s_q && rx_emit)
			begin
				rx_cur_q <= rx_idx;
			end
			// A resumed packet carries no second start flag
			if (rx_emit)
			begin
				rx_mid_q[rx_src_sel] <= !rx_src_eop;
			end
		end
	end

	// Receive bus outputs
	logic rx_strobe_now;

	assign rx_strobe_now = mode_s_q && rx_state_q == PBPHY_RX_IDLE && rx_read_enable
		&& rx_pick[PW];

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_polled_data_available  <= PBPHY_RST_LOW;
			rx_valid                  <= PBPHY_RST_LOW;
			rx_data_bus               <= '0;
			rx_start_of_packet        <= PBPHY_RST_LOW;
			rx_end_of_packet          <= PBPHY_RST_LOW;
			rx_packet_error           <= PBPHY_RST_LOW;
			rx_in_band_address_strobe <= PBPHY_RST_LOW;
			rx_bus_oe_n               <= PBPHY_RST_OE_N;
		end
		else
		begin
			rx_polled_data_available  <= !mode_s_q && rx_hit && avail_s_q[rx_idx];
			rx_valid                  <= rx_emit;
			rx_start_of_packet        <= rx_emit && !rx_mid_q[rx_src_sel];
			rx_end_of_packet          <= rx_emit && rx_src_eop;
			rx_packet_error           <= rx_emit && rx_src_eop && rx_src_err;
			rx_in_band_address_strobe <= rx_strobe_now;
			if (rx_strobe_now)
			begin
				rx_data_bus <= DW'(PORT_BASE + AW'(rx_pick[PW-1:0]));
			end
			else if (rx_emit)
			begin
				rx_data_bus <= rx_src_data;
			end
			if (mode_s_q)
			begin
				rx_bus_oe_n <= 1'b0;
			end
			else
			begin
				rx_bus_oe_n <= !(rx_emit || (!rx_bus_oe_n && !rx_release));
			end
		end
	end

endmodule // pbphy_transfer

// File: test/pbphy_checker.sv
// Purpose: Bus-side timing checks of pbphy_transfer
// Assumes: Port addresses start at zero
// Notes:   Link-domain relations only
`timescale 1ns/100ps
module pbphy_checker #(
	parameter int NUM_PORTS = 4,
	parameter int DW = 8,
	parameter int AW = 5
) (
	input wire logic	sys_clk,
	input wire logic	rst,
	input wire logic [AW-1:0]	tx_port_address,
	input wire logic	transmit_enable,
	input wire logic	tx_in_band_address_strobe,
	input wire logic	tx_polled_space_available,
	input wire logic	tx_selected_space_oe_n,
	input wire logic	tx_byte_valid,
	input wire logic	tx_byte_sop,
	input wire logic [AW-1:0]	rx_port_address,
	input wire logic	rx_read_enable,
	input wire logic	rx_polled_data_available,
	input wire logic	rx_valid,
	input wire logic [DW-1:0]	rx_data_bus,
	input wire logic	rx_start_of_packet,
	input wire logic	rx_end_of_packet,
	input wire logic	rx_bus_oe_n,
	input wire logic	rx_in_band_address_strobe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_tx_poll;
		int'(tx_port_address) >= NUM_PORTS |=> !tx_polled_space_available;
	endproperty
	a_tx_poll: assert property (p_tx_poll) else $error("foreign tx poll answered");
	property p_tx_idle;
		!transmit_enable && !tx_in_band_address_strobe |=> !tx_byte_valid;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("idle bus byte taken");
	property p_tx_drive;
		tx_byte_valid && tx_byte_sop |=> !tx_selected_space_oe_n;
	endproperty
	a_tx_drive: assert property (p_tx_drive) else $error("space not driven");
	property p_rx_poll;
		int'(rx_port_address) >= NUM_PORTS |=> !rx_polled_data_available;
	endproperty
	a_rx_poll: assert property (p_rx_poll) else $error("foreign rx poll answered");
	property p_rx_sop;
		rx_start_of_packet |-> rx_valid ##1 !rx_start_of_packet;
	endproperty
	a_rx_sop: assert property (p_rx_sop) else $error("start flag not a pulse");
	property p_rx_eop;
		rx_end_of_packet |=> !rx_valid && !rx_end_of_packet;
	endproperty
	a_rx_eop: assert property (p_rx_eop) else $error("valid after end");
	property p_rx_drive;
		rx_valid |-> !rx_bus_oe_n;
	endproperty
	a_rx_drive: assert property (p_rx_drive) else $error("valid while floating");
	property p_rx_addr;
		rx_in_band_address_strobe && rx_read_enable |-> int'(rx_data_bus) < NUM_PORTS
			##1 !rx_in_band_address_strobe && rx_valid && rx_start_of_packet;
	endproperty
	a_rx_addr: assert property (p_rx_addr) else $error("bad address cycle");
endmodule // pbphy_checker
bind pbphy_transfer pbphy_checker #(.NUM_PORTS(NUM_PORTS), .DW(DW), .AW(AW)) u_chk (.*);

// File: test/pbphy_rx_source.sv
// Purpose: Per-port receive byte queues behind the PHY
// Assumes: Fixed packet length, port 1 ends in error
// Notes:   Byte is {port, index} so order slips show
`timescale 1ns/100ps
module pbphy_rx_source #(
	parameter int LEN = 3
) (
	input wire logic	sys_clk,
	input wire logic	rst,
	input wire logic [1:0]	sel,
	input wire logic	take,
	output logic [7:0]	data,
	output logic	eop,
	output logic	err
);
	logic [3:0]	cnt_q [4];
	assign data = {2'b00, sel, cnt_q[sel]};
	assign eop = cnt_q[sel] == 4'(LEN - 1);
	assign err = eop && sel == 2'd1;
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			cnt_q <= '{default: 4'h0};
		else if (take)
			cnt_q[sel] <= eop ? 4'h0 : cnt_q[sel] + 4'h1;
endmodule // pbphy_rx_source

// File: test/tb_top.sv
// Purpose: Self-checking bench of pbphy_transfer
// Assumes: Default ports 0..3 at base 0
// Notes:   Bus inputs move at falling sys_clk
`timescale 1ns/100ps
module tb_top;
	localparam int LEN = 3;
	logic	core_clk = 1'b0, sys_clk = 1'b0, rst = 1'b1;
	logic	core_level3_mode = 1'b0, transmit_enable = 1'b0, rx_read_enable = 1'b0;
	logic	tx_start_of_packet = 1'b0, tx_end_of_packet = 1'b0;
	logic	tx_in_band_address_strobe = 1'b0;
	logic [3:0]	core_tx_space = 4'h5, core_rx_avail = 4'h3;
	logic [4:0]	tx_port_address = 5'h00, rx_port_address = 5'h00;
	logic [7:0]	tx_data_bus = 8'h00, tx_byte_data, rx_data_bus, rx_src_data;
	logic [1:0]	tx_byte_port, rx_src_sel;
	logic	core_tx_packet_done, tx_polled_space_available, tx_selected_space_available;
	logic	tx_selected_space_oe_n, tx_byte_valid, tx_byte_sop, tx_byte_eop;
	logic	rx_polled_data_available, rx_valid, rx_start_of_packet, rx_end_of_packet;
	logic	rx_packet_error, rx_bus_oe_n, rx_in_band_address_strobe, rx_src_take;
	logic	rx_src_eop, rx_src_err;
	int	mismatches = 0, samples_checked = 0, cycles = 0, done_seen = 0;
	always #5 core_clk = ~core_clk;
	always #62.5 sys_clk = ~sys_clk;
	pbphy_transfer dut (.*);
	pbphy_rx_source #(.LEN(LEN)) src (.sys_clk, .rst, .sel(rx_src_sel), .take(rx_src_take),
		.data(rx_src_data), .eop(rx_src_eop), .err(rx_src_err));
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (core_tx_packet_done === 1'b1)
			done_seen <= done_seen + 1;
		if (cycles == 20000)
		begin
			mismatches = mismatches + 1;
			complete_run();
		end
	end
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (mismatches == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic t_poll();
		for (int a = 0; a < 5; a++)
		begin
			tx_port_address = 5'(a);
			rx_port_address = 5'(a);
			tick(1);
			chk("tx_poll", 8'(tx_polled_space_available), 8'(a < 4 && core_tx_space[a]));
			chk("rx_poll", 8'(rx_polled_data_available), 8'(a < 4 && core_rx_avail[a]));
		end
	endtask
	task automatic t_tx_l2();
		tx_port_address = 5'h02;
		tick(1);
		transmit_enable = 1'b1;
		tx_start_of_packet = 1'b1;
		tx_data_bus = 8'ha0;
		tick(1);
		chk("tx_sop", {5'h00, tx_byte_valid, tx_byte_sop, tx_byte_eop}, 8'h06);
		chk("tx_port", {6'h00, tx_byte_port}, 8'h02);
		chk("tx_data", tx_byte_data, 8'ha0);
		tx_start_of_packet = 1'b0;
		tx_end_of_packet = 1'b1;
		tx_port_address = 5'h00;
		tx_data_bus = 8'ha1;
		tick(1);
		chk("tx_eop", {5'h00, tx_byte_valid, tx_byte_sop, tx_byte_eop}, 8'h05);
		chk("tx_drv", {6'h00, tx_selected_space_oe_n, tx_selected_space_available}, 8'h01);
		chk("tx_poll_busy", 8'(tx_polled_space_available), 8'h01);
		transmit_enable = 1'b0;
		tx_end_of_packet = 1'b0;
		tick(1);
		transmit_enable = 1'b1;
		tx_start_of_packet = 1'b1;
		tx_port_address = 5'h09;
		tick(1);
		chk("tx_foreign", 8'(tx_byte_valid), 8'h00);
		chk("tx_hold", {7'h00, tx_selected_space_oe_n}, 8'h00);
		tx_start_of_packet = 1'b0;
		tick(1);
		chk("tx_float", {7'h00, tx_selected_space_oe_n}, 8'h01);
		transmit_enable = 1'b0;
		tick(2);
		chk("tx_done", 8'(done_seen), 8'h01);
	endtask
	task automatic rx_bytes(input logic [1:0] p);
		for (int i = 0; i < LEN; i++)
		begin
			tick(1);
			chk("rx_val", {6'h00, rx_valid, rx_start_of_packet}, {6'h00, 1'b1, i == 0});
			chk("rx_eop", 8'(rx_end_of_packet), 8'(i == LEN - 1));
			chk("rx_err", 8'(rx_packet_error), 8'(i == LEN - 1 && p == 2'd1));
			chk("rx_data", rx_data_bus, {2'b00, p, 4'(i)});
		end
	endtask
	task automatic rx_pkt(input logic [1:0] p);
		rx_port_address = {3'b000, p};
		rx_read_enable = 1'b1;
		rx_bytes(p);
		tick(1);
		chk("rx_end", {6'h00, rx_valid, rx_end_of_packet}, 8'h00);
		rx_read_enable = 1'b0;
		tick(1);
	endtask
	task automatic t_rx_l2();
		rx_pkt(2'd0);
		rx_pkt(2'd0);
		rx_pkt(2'd1);
		rx_port_address = 5'h09;
		tick(1);
		chk("rx_float", {7'h00, rx_bus_oe_n}, 8'h01);
	endtask
	task automatic t_l3();
		core_level3_mode = 1'b1;
		core_rx_avail = 4'h1;
		tick(3);
		tx_in_band_address_strobe = 1'b1;
		tx_data_bus = 8'h02;
		tick(1);
		tx_in_band_address_strobe = 1'b0;
		transmit_enable = 1'b1;
		tx_start_of_packet = 1'b1;
		tx_data_bus = 8'hb0;
		tick(1);
		chk("l3_drv", {7'h00, tx_selected_space_oe_n}, 8'h00);
		chk("l3_tx", {5'h00, tx_byte_valid, tx_byte_sop, tx_byte_port == 2'd2}, 8'h07);
		tx_start_of_packet = 1'b0;
		tx_data_bus = 8'hb1;
		tx_port_address = 5'h00;
		tick(1);
		chk("l3_space", 8'(tx_selected_space_available), 8'h01);
		chk("l3_poll", 8'(tx_polled_space_available), 8'h01);
		transmit_enable = 1'b0;
		tx_in_band_address_strobe = 1'b1;
		tx_data_bus = 8'h00;
		tick(1);
		tx_in_band_address_strobe = 1'b0;
		rx_read_enable = 1'b1;
		tick(1);
		chk("l3_end", 8'(tx_selected_space_available), 8'h00);
		chk("l3_addr", {rx_in_band_address_strobe, rx_data_bus[6:0]}, 8'h80);
		core_rx_avail = 4'h4;
		rx_bytes(2'd0);
		tick(1);
		chk("l3_next", {rx_in_band_address_strobe, rx_valid, rx_data_bus[5:0]}, 8'h82);
		rx_bytes(2'd2);
		rx_read_enable = 1'b0;
	endtask
	initial
	begin
		tick(5);
		rst = 1'b0;
		tick(3);
		t_poll();
		t_tx_l2();
		t_rx_l2();
		t_l3();
		tick(2);
		complete_run();
	end
endmodule // tb_top
